// ---- inc/devmap_cfg_consts.svh ----
// constants for the device-region base and core capability registers
`ifndef DEVMAP_CFG_CONSTS_SVH
`define DEVMAP_CFG_CONSTS_SVH

// coprocessor register number and select of each register
`define DEVMAP_REG_NUM 5'h0f
`define DEVMAP_REG_SEL 3'h2
`define CFG_REG_NUM 5'h10
`define CFG_REG_SEL 3'h0

// device-region base register fields
`define BASE_UPPER_MSB 31
`define BASE_UPPER_LSB 11
`define BASE_PA_LSB 15
`define BASE_PA_W 36
`define REGION_EN_BIT 10
`define CTRL_BLOCK_BIT 9
`define BLOCK_COUNT_MSB 8
`define BLOCK_OFS_LSB 6
`define PA_BITS_MIN 16

// capability word fields
`define CFG_NEXT_BIT 31
`define CFG_K23_MSB 30
`define CFG_K23_LSB 28
`define CFG_KU_MSB 27
`define CFG_KU_LSB 25
`define CFG_ISP_BIT 24
`define CFG_DSP_BIT 23
`define CFG_UDI_BIT 22
`define CFG_SB_BIT 21
`define CFG_MDU_BIT 20
`define CFG_DIAG_BIT 19
`define CFG_MM_MSB 18
`define CFG_MM_LSB 17
`define CFG_BM_BIT 16
`define CFG_BE_BIT 15

// reset values and cache policy codes
`define POLICY_RESET_FM 3'h2
`define POLICY_RESET_TLB 3'h0
`define POL_WT_NOALLOC 3'h0
`define POL_WT_ALLOC 3'h1
`define POL_UNCACHED 3'h2
`define POL_WB_ALLOC 3'h3
`define WORD_ZERO 32'h0000_0000

`endif

// ---- inc/devmap_cfg_pkg.sv ----
// types and the cache policy decode shared by the register bank
`default_nettype none
`include "devmap_cfg_consts.svh"
package devmap_cfg_pkg;

  localparam int unsigned BASE_W = `BASE_UPPER_MSB - `BASE_UPPER_LSB + 1;

  typedef enum logic [1:0] {
    RD_NONE = 2'b00,
    RD_BASE = 2'b01,
    RD_CFG  = 2'b10
  } rd_src_e;

  // one coprocessor access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] num;
    logic [2:0] sel;
    logic [31:0] wdata;
  } cp_req_s;

  // static configuration pins
  typedef struct packed {
    logic instr_scratchpad_pin;
    logic data_scratchpad_pin;
    logic [1:0] merge_mode_pins;
    logic endian_pin;
  } static_pins_s;

  typedef struct packed {
    logic [BASE_W-1:0] base_upper;
    logic region_en;
    logic [2:0] k23;
    logic [2:0] ku;
    logic [31:0] rd_data;
    logic rd_valid;
    rd_src_e rd_src;
    logic [2:0] k23_eff;
    logic [2:0] ku_eff;
    logic to_region;
    logic to_memory;
  } state_s;

  // unused policy codes fold onto the four that the core serves
  function automatic logic [2:0] policy_decode(input logic [2:0] c);
    logic [2:0] r;
    r = `POL_UNCACHED;
    unique case (c)
      3'h0: r = `POL_WT_NOALLOC;
      3'h1: r = `POL_WT_ALLOC;
      3'h2: r = `POL_UNCACHED;
      3'h3: r = `POL_WB_ALLOC;
      3'h4: r = `POL_WB_ALLOC;
      3'h5: r = `POL_WB_ALLOC;
      3'h6: r = `POL_WB_ALLOC;
      3'h7: r = `POL_UNCACHED;
    endcase
    return r;
  endfunction

endpackage
`default_nettype wire

// ---- design/cache_policy_decode.sv ----
// maps a programmed cacheability code onto the policy actually applied
`timescale 1ns/1ns
`default_nettype none
module cache_policy_decode
  import devmap_cfg_pkg::*;
(
  input wire logic [2:0] code_i,
  output logic [2:0] policy_o
);

  // 4..6 act as write-back allocate, 7 as uncached
  assign policy_o = policy_decode(code_i);

endmodule
`default_nettype wire

// ---- design/devmap_region_match.sv ----
// decides whether a physical request falls inside the device region
`timescale 1ns/1ns
`default_nettype none
`include "devmap_cfg_consts.svh"
module devmap_region_match
  import devmap_cfg_pkg::*;
(
  input wire logic [`BASE_PA_W-1:0] addr_i,
  input wire logic [BASE_W-1:0] base_upper_i,
  input wire logic region_en_i,
  input wire logic [`BLOCK_COUNT_MSB:0] block_count_i,
  output logic hit_o
);

  logic upper_eq;
  logic block_in;

  // region is 32 KB aligned and holds block_count+1 blocks of 64 bytes
  assign upper_eq = addr_i[`BASE_PA_W-1:`BASE_PA_LSB] == base_upper_i;
  assign block_in = addr_i[`BASE_PA_LSB-1:`BLOCK_OFS_LSB] <= block_count_i;
  // disabled region leaves every request to system memory
  assign hit_o = region_en_i & upper_eq & block_in;

endmodule
`default_nettype wire

// ---- design/cp0_devmap_base_and_config_regs.sv ----
// device-region base register and core capability word behind coprocessor access
`timescale 1ns/1ns
`default_nettype none
`include "devmap_cfg_consts.svh"
module cp0_devmap_base_and_config_regs
  import devmap_cfg_pkg::*;
#(
  parameter bit HAS_DEVMAP = 1'b1,
  parameter bit FIXED_MAPPING = 1'b1,
  parameter int unsigned PA_BITS = `BASE_PA_W,
  parameter bit CTRL_BLOCK = 1'b0,
  parameter logic [`BLOCK_COUNT_MSB:0] BLOCK_COUNT = 9'h000,
  parameter bit USER_EXT = 1'b0,
  parameter bit MULDIV_ITER = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire cp_req_s cp_req_i,
  input wire static_pins_s pins_i,
  input wire logic req_valid_i,
  input wire logic [`BASE_PA_W-1:0] req_addr_i,
  output logic [31:0] rd_data_o,
  output logic rd_valid_o,
  output logic region_en_o,
  output logic [`BASE_PA_W-1:0] region_base_o,
  output logic [2:0] upper_kernel_policy_o,
  output logic [2:0] user_seg_policy_o,
  output logic req_to_region_o,
  output logic req_to_memory_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks and derived constants

  if (PA_BITS < `PA_BITS_MIN || PA_BITS > `BASE_PA_W) begin : g_pa_check
    $error("physical address width out of range");
  end

  // one bit per base field bit: set where the physical address bit exists
  function automatic logic [BASE_W-1:0] impl_mask(input int unsigned pa);
    logic [BASE_W-1:0] m;
    m = '0;
    for (int i = 0; i < BASE_W; i++) begin
      m[i] = (i + `BASE_PA_LSB) < pa;
    end
    return m;
  endfunction

  localparam logic [BASE_W-1:0] IMPL_MASK = impl_mask(PA_BITS);
  localparam logic [2:0] POL_RESET = FIXED_MAPPING ? `POLICY_RESET_FM : `POLICY_RESET_TLB;

  // every control field has a constant after reset
  localparam state_s RST = '{
    base_upper: '0,
    region_en: 1'b0,
    k23: POL_RESET,
    ku: POL_RESET,
    rd_data: `WORD_ZERO,
    rd_valid: 1'b0,
    rd_src: RD_NONE,
    k23_eff: policy_decode(POL_RESET),
    ku_eff: policy_decode(POL_RESET),
    to_region: 1'b0,
    to_memory: 1'b0
  };

  ////////////////////////////////////////////////////////////////////////////////
  // access decode and read words

  state_s s_q;
  state_s s_d;
  logic is_base;
  logic is_cfg;
  logic wr_en_bit;
  logic [2:0] k23_dec;
  logic [2:0] ku_dec;
  logic region_hit;
  logic [31:0] base_word;
  logic [31:0] cfg_word;

  assign is_base = cp_req_i.num == `DEVMAP_REG_NUM && cp_req_i.sel == `DEVMAP_REG_SEL;
  assign is_cfg = cp_req_i.num == `CFG_REG_NUM && cp_req_i.sel == `CFG_REG_SEL;
  assign wr_en_bit = cp_req_i.wdata[`REGION_EN_BIT];

  // absent register reads as zero
  always_comb begin
    base_word = `WORD_ZERO;
    if (HAS_DEVMAP) begin
      base_word[`BASE_UPPER_MSB:`BASE_UPPER_LSB] = s_q.base_upper;
      base_word[`REGION_EN_BIT] = s_q.region_en;
      base_word[`CTRL_BLOCK_BIT] = CTRL_BLOCK;
      base_word[`BLOCK_COUNT_MSB:0] = BLOCK_COUNT;
    end
  end

  // capability word; bits 14:0 are outside this bank and read zero
  always_comb begin
    cfg_word = `WORD_ZERO;
    cfg_word[`CFG_NEXT_BIT] = 1'b1;
    cfg_word[`CFG_K23_MSB:`CFG_K23_LSB] = s_q.k23;
    cfg_word[`CFG_KU_MSB:`CFG_KU_LSB] = s_q.ku;
    cfg_word[`CFG_ISP_BIT] = pins_i.instr_scratchpad_pin;
    cfg_word[`CFG_DSP_BIT] = pins_i.data_scratchpad_pin;
    cfg_word[`CFG_UDI_BIT] = USER_EXT;
    cfg_word[`CFG_SB_BIT] = 1'b1;
    cfg_word[`CFG_MDU_BIT] = MULDIV_ITER;
    cfg_word[`CFG_DIAG_BIT] = 1'b0;
    cfg_word[`CFG_MM_MSB:`CFG_MM_LSB] = pins_i.merge_mode_pins;
    cfg_word[`CFG_BM_BIT] = 1'b0;
    cfg_word[`CFG_BE_BIT] = pins_i.endian_pin;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // policy decode and region match

  cache_policy_decode u_k23_dec (
    .code_i(s_q.k23),
    .policy_o(k23_dec)
  );

  cache_policy_decode u_ku_dec (
    .code_i(s_q.ku),
    .policy_o(ku_dec)
  );

  devmap_region_match u_match (
    .addr_i(req_addr_i),
    .base_upper_i(s_q.base_upper),
    .region_en_i(s_q.region_en & HAS_DEVMAP),
    .block_count_i(BLOCK_COUNT),
    .hit_o(region_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    if (ce_i) begin
      // read answers one cycle later with the value before any same-cycle write
      s_d.rd_valid = cp_req_i.rd;
      s_d.rd_src = RD_NONE;
      s_d.rd_data = `WORD_ZERO;
      if (cp_req_i.rd && is_base) begin
        s_d.rd_src = RD_BASE;
        s_d.rd_data = base_word;
      end else if (cp_req_i.rd && is_cfg) begin
        s_d.rd_src = RD_CFG;
        s_d.rd_data = cfg_word;
      end
      // only the address field and enable take write data
      if (cp_req_i.wr && is_base && HAS_DEVMAP) begin
        s_d.base_upper = cp_req_i.wdata[`BASE_UPPER_MSB:`BASE_UPPER_LSB] & IMPL_MASK;
        s_d.region_en = wr_en_bit;
      end
      // policies are writable only on fixed-mapping cores
      if (cp_req_i.wr && is_cfg && FIXED_MAPPING) begin
        s_d.k23 = cp_req_i.wdata[`CFG_K23_MSB:`CFG_K23_LSB];
        s_d.ku = cp_req_i.wdata[`CFG_KU_MSB:`CFG_KU_LSB];
      end
      s_d.k23_eff = k23_dec;
      s_d.ku_eff = ku_dec;
      // route each request either to the region or to system memory
      s_d.to_region = req_valid_i & region_hit;
      s_d.to_memory = req_valid_i & ~region_hit;
    end
  end

  // state register; reset brings all fields to their defined values
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rd_data_o = s_q.rd_data;
  assign rd_valid_o = s_q.rd_valid;
  assign region_en_o = s_q.region_en;
  assign region_base_o = {s_q.base_upper, 15'h0000};
  assign upper_kernel_policy_o = s_q.k23_eff;
  assign user_seg_policy_o = s_q.ku_eff;
  assign req_to_region_o = s_q.to_region;
  assign req_to_memory_o = s_q.to_memory;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions and covers

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // read answered in the next cycle
  read_answer_a: assert property (ce_i && cp_req_i.rd |=> rd_valid_o)
    else $error("read not answered one cycle later");

  // fixed capability bits
  cfg_fixed_bits_a: assert property (rd_valid_o && s_q.rd_src == RD_CFG |->
    rd_data_o[31] && rd_data_o[21] && !rd_data_o[19] && !rd_data_o[16] &&
    rd_data_o[22] == USER_EXT && rd_data_o[20] == MULDIV_ITER)
    else $error("fixed capability bit wrong");

  // pin fields show the pins at read time
  cfg_pin_bits_a: assert property (ce_i && cp_req_i.rd && is_cfg |=>
    rd_data_o[24] == $past(pins_i.instr_scratchpad_pin) &&
    rd_data_o[23] == $past(pins_i.data_scratchpad_pin) &&
    rd_data_o[18:17] == $past(pins_i.merge_mode_pins) &&
    rd_data_o[15] == $past(pins_i.endian_pin))
    else $error("pin field does not follow pin");

  // enable bit takes written value
  region_enable_a: assert property (ce_i && cp_req_i.wr && is_base && HAS_DEVMAP |=>
    region_en_o == $past(wr_en_bit))
    else $error("region enable not written");

  // preset low fields of base register
  base_preset_a: assert property (rd_valid_o && s_q.rd_src == RD_BASE && HAS_DEVMAP |->
    rd_data_o[9] == CTRL_BLOCK && rd_data_o[8:0] == BLOCK_COUNT)
    else $error("base preset field wrong");

  // unimplemented address bits read zero
  unimpl_zero_a: assert property (rd_valid_o && s_q.rd_src == RD_BASE |->
    (rd_data_o[31:11] & ~IMPL_MASK) == '0)
    else $error("unimplemented address bit nonzero");

  // absent base register reads zero
  absent_reg_a: assert property (rd_valid_o && s_q.rd_src == RD_BASE && !HAS_DEVMAP |->
    rd_data_o == `WORD_ZERO)
    else $error("absent register not zero");

  // tlb cores keep policy fields zero
  tlb_policy_a: assert property (rd_valid_o && s_q.rd_src == RD_CFG && !FIXED_MAPPING |->
    rd_data_o[30:25] == 6'h00)
    else $error("reserved policy field nonzero");

  // applied policy follows stored code through the decode
  policy_map_a: assert property (ce_i |=>
    upper_kernel_policy_o == policy_decode($past(s_q.k23)) &&
    user_seg_policy_o == policy_decode($past(s_q.ku)))
    else $error("policy decode wrong");

  // disabled region never claims a request
  route_mem_a: assert property (ce_i && req_valid_i && !region_en_o |=>
    req_to_memory_o && !req_to_region_o)
    else $error("request routed to disabled region");

  // register written with address then read back
  base_rdback_a: assert property (ce_i && cp_req_i.wr && is_base && HAS_DEVMAP ##1
    ce_i && cp_req_i.rd && is_base && !cp_req_i.wr |=>
    rd_data_o[31:11] == ($past(cp_req_i.wdata[31:11], 2) & IMPL_MASK))
    else $error("base address not read back");

  // a taken request goes to exactly one side
  route_one_a: assert property (ce_i && req_valid_i |=>
    req_to_region_o != req_to_memory_o)
    else $error("request routed to both or neither side");

  // enabled region claims requests inside its blocks
  region_hit_a: assert property (ce_i && req_valid_i && region_en_o && HAS_DEVMAP &&
    req_addr_i[35:15] == s_q.base_upper && req_addr_i[14:6] <= BLOCK_COUNT |=>
    req_to_region_o)
    else $error("request inside enabled region not claimed");

  // fixed-mapping cores store the written policy codes
  policy_store_a: assert property (ce_i && cp_req_i.wr && is_cfg && FIXED_MAPPING |=>
    s_q.k23 == $past(cp_req_i.wdata[30:28]) &&
    s_q.ku == $past(cp_req_i.wdata[27:25]))
    else $error("policy code not stored");

  // tlb cores apply policy code zero to both segments
  tlb_out_a: assert property (!FIXED_MAPPING |->
    upper_kernel_policy_o == 3'h0 && user_seg_policy_o == 3'h0)
    else $error("tlb core applies nonzero policy");

  enable_write_c: cover property (ce_i && cp_req_i.wr && is_base && wr_en_bit);
  cfg_read_c: cover property (rd_valid_o && s_q.rd_src == RD_CFG);
  region_hit_c: cover property (req_to_region_o);
  policy_write_c: cover property (ce_i && cp_req_i.wr && is_cfg ##1 upper_kernel_policy_o != 3'h2);
  ce_hold_c: cover property (!ce_i && cp_req_i.wr);

endmodule
`default_nettype wire

// ---- testbench/cp0_devmap_base_and_config_regs_tb_top.sv ----
// self-checking bench for the device-region base and capability registers
`timescale 1ns/1ns
`default_nettype none
`include "devmap_cfg_consts.svh"
module cp0_devmap_base_and_config_regs_tb_top
  import devmap_cfg_pkg::*;
;
  localparam logic [8:0] BLK = 9'h003;
  localparam bit UEXT = 1'h1;
  localparam bit MITER = 1'h1;
  localparam int LIMIT = 20000;
  logic sys_clk_i;
  logic rst_i;
  logic ce_i;
  cp_req_s req;
  static_pins_s pins;
  logic req_valid;
  logic [35:0] req_addr;
  logic [31:0] rd_data;
  logic rd_valid;
  logic region_en;
  logic [35:0] region_base;
  logic [2:0] k_pol;
  logic [2:0] u_pol;
  logic to_region;
  logic to_memory;
  logic [31:0] t_rd_data;
  logic [35:0] t_region_base;
  logic [2:0] t_k_pol;
  logic [2:0] t_u_pol;
  logic [31:0] a_rd_data;
  logic a_to_memory;
  logic [21:0] base_sh;
  logic [2:0] k23_sh;
  logic [2:0] ku_sh;
  logic [31:0] wd;
  logic [8:0] blk;
  logic [20:0] up;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int unsigned seed;

  cp0_devmap_base_and_config_regs #(
    .HAS_DEVMAP(1'h1), .FIXED_MAPPING(1'h1), .PA_BITS(36), .CTRL_BLOCK(1'h0),
    .BLOCK_COUNT(BLK), .USER_EXT(UEXT), .MULDIV_ITER(MITER)
  ) cp0_devmap_base_and_config_regs_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .cp_req_i(req), .pins_i(pins),
    .req_valid_i(req_valid), .req_addr_i(req_addr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .region_en_o(region_en), .region_base_o(region_base),
    .upper_kernel_policy_o(k_pol), .user_seg_policy_o(u_pol),
    .req_to_region_o(to_region), .req_to_memory_o(to_memory)
  );

  // tlb core with a 24-bit physical address and the control block flagged
  cp0_devmap_base_and_config_regs #(
    .HAS_DEVMAP(1'h1), .FIXED_MAPPING(1'h0), .PA_BITS(24), .CTRL_BLOCK(1'h1),
    .BLOCK_COUNT(BLK), .USER_EXT(1'h0), .MULDIV_ITER(1'h0)
  ) cp0_devmap_base_and_config_regs_tlb_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .cp_req_i(req), .pins_i(pins),
    .req_valid_i(req_valid), .req_addr_i(req_addr), .rd_data_o(t_rd_data),
    .rd_valid_o(), .region_en_o(), .region_base_o(t_region_base),
    .upper_kernel_policy_o(t_k_pol), .user_seg_policy_o(t_u_pol),
    .req_to_region_o(), .req_to_memory_o()
  );

  // core built without the device memory map
  cp0_devmap_base_and_config_regs #(
    .HAS_DEVMAP(1'h0), .FIXED_MAPPING(1'h1), .PA_BITS(36), .CTRL_BLOCK(1'h0),
    .BLOCK_COUNT(BLK), .USER_EXT(UEXT), .MULDIV_ITER(MITER)
  ) cp0_devmap_base_and_config_regs_absent_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .cp_req_i(req), .pins_i(pins),
    .req_valid_i(req_valid), .req_addr_i(req_addr), .rd_data_o(a_rd_data),
    .rd_valid_o(), .region_en_o(), .region_base_o(),
    .upper_kernel_policy_o(), .user_seg_policy_o(),
    .req_to_region_o(), .req_to_memory_o(a_to_memory)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    sys_clk_i = 1'h0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("[ERR] timeout expected end seen hang");
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // expectations and transfer tasks
  function automatic logic [31:0] base_exp();
    return {base_sh, 1'h0, BLK};
  endfunction

  function automatic logic [31:0] cfg_exp();
    return {1'h1, k23_sh, ku_sh, pins.instr_scratchpad_pin, pins.data_scratchpad_pin,
            UEXT, 1'h1, MITER, 1'h0, pins.merge_mode_pins, 1'h0, pins.endian_pin, 15'h0000};
  endfunction

  // folds unused policy codes onto served ones
  function automatic logic [2:0] pol(input logic [2:0] c);
    case (c)
      3'h0, 3'h1, 3'h2: return c;
      3'h7: return 3'h2;
      default: return 3'h3;
    endcase
  endfunction

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access, held for one taking edge; results settled on return
  task automatic access(input logic rd, input logic wr, input logic [4:0] num,
                        input logic [2:0] sel, input logic [31:0] d);
    @(posedge sys_clk_i);
    #1;
    req = '{rd: rd, wr: wr, num: num, sel: sel, wdata: d};
    @(posedge sys_clk_i);
    #1;
    req.rd = 1'h0;
    req.wr = 1'h0;
  endtask

  task automatic rd_chk(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] e);
    access(1'h1, 1'h0, num, sel, 32'h0000_0000);
    chk("rd_valid", 36'h1, rd_valid);
    chk("rd_data", e, rd_data);
    // the narrow tlb core and the core without the map answer the same read
    if (num == `DEVMAP_REG_NUM) begin
      chk("t_rd_data", {12'h000, base_sh[9:0], 1'h1, BLK}, t_rd_data);
      chk("a_rd_data", 36'h0, a_rd_data);
    end else begin
      chk("t_rd_data", e & 32'h81af_ffff, t_rd_data);
      chk("a_rd_data", e, a_rd_data);
    end
  endtask

  task automatic route(input logic [35:0] a, input logic hit);
    @(posedge sys_clk_i);
    #1;
    req_valid = 1'h1;
    req_addr = a;
    @(posedge sys_clk_i);
    #1;
    req_valid = 1'h0;
    chk("to_region", hit, to_region);
    chk("to_memory", !hit, to_memory);
    chk("a_to_memory", 36'h1, a_to_memory);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_i = 1'h1;
    ce_i = 1'h1;
    req = '0;
    pins = '0;
    req_valid = 1'h0;
    req_addr = '0;
    base_sh = '0;
    k23_sh = 3'h2;
    ku_sh = 3'h2;
    seed = $urandom(43939);
    repeat (16) @(posedge sys_clk_i);
    #1;
    rst_i = 1'h0;
    // reset state of both registers
    chk("region_en", 36'h0, region_en);
    chk("k_pol", 36'h2, k_pol);
    chk("u_pol", 36'h2, u_pol);
    chk("rd_valid", 36'h0, rd_valid);
    chk("t_k_pol", 36'h0, t_k_pol);
    chk("t_u_pol", 36'h0, t_u_pol);
    rd_chk(`DEVMAP_REG_NUM, `DEVMAP_REG_SEL, base_exp());
    pins = 5'($urandom);
    rd_chk(`CFG_REG_NUM, `CFG_REG_SEL, cfg_exp());
    $display("test reset_values done");
    // base writes incl. all ones into read-only bits
    for (int i = 0; i < 8; i++) begin
      wd = (i == 0) ? 32'hffff_ffff : $urandom;
      access(1'h0, 1'h1, `DEVMAP_REG_NUM, `DEVMAP_REG_SEL, wd);
      base_sh = wd[31:10];
      chk("region_en", wd[10], region_en);
      chk("region_base", {wd[31:11], 15'h0000}, region_base);
      chk("t_region_base", {12'h000, wd[19:11], 15'h0000}, t_region_base);
      rd_chk(`DEVMAP_REG_NUM, `DEVMAP_REG_SEL, base_exp());
    end
    // write and read on consecutive edges; the read sees the new word
    wd = $urandom;
    @(posedge sys_clk_i);
    #1;
    req = '{rd: 1'h0, wr: 1'h1, num: `DEVMAP_REG_NUM, sel: `DEVMAP_REG_SEL, wdata: wd};
    @(posedge sys_clk_i);
    #1;
    req.rd = 1'h1;
    req.wr = 1'h0;
    @(posedge sys_clk_i);
    #1;
    req.rd = 1'h0;
    base_sh = wd[31:10];
    chk("rd_next", base_exp(), rd_data);
    // read and write in one cycle returns the old word
    access(1'h1, 1'h1, `DEVMAP_REG_NUM, `DEVMAP_REG_SEL, ~base_exp());
    chk("rd_old", base_exp(), rd_data);
    base_sh = ~base_sh;
    // clock enable low: a write is not taken and the old word stays
    ce_i = 1'h0;
    access(1'h0, 1'h1, `DEVMAP_REG_NUM, `DEVMAP_REG_SEL, ~base_exp());
    ce_i = 1'h1;
    chk("frozen_base", {base_sh[21:1], 15'h0000}, region_base);
    chk("frozen_en", base_sh[0], region_en);
    rd_chk(`DEVMAP_REG_NUM, `DEVMAP_REG_SEL, base_exp());
    $display("test base_writes done");
    // every policy code in both fields, with random pins
    for (int i = 0; i < 8; i++) begin
      wd = $urandom;
      wd[30:28] = 3'(i);
      wd[27:25] = 3'(7 - i);
      pins = 5'($urandom);
      access(1'h0, 1'h1, `CFG_REG_NUM, `CFG_REG_SEL, wd);
      k23_sh = wd[30:28];
      ku_sh = wd[27:25];
      @(posedge sys_clk_i);
      #1;
      chk("k_pol", pol(k23_sh), k_pol);
      chk("u_pol", pol(ku_sh), u_pol);
      rd_chk(`CFG_REG_NUM, `CFG_REG_SEL, cfg_exp());
    end
    // a write to a neighbouring select leaves the policies alone
    access(1'h0, 1'h1, `CFG_REG_NUM, 3'h1, 32'hffff_ffff);
    rd_chk(`CFG_REG_NUM, `CFG_REG_SEL, cfg_exp());
    $display("test config_writes done");
    // routing at block boundaries and at random
    up = 21'($urandom);
    access(1'h0, 1'h1, `DEVMAP_REG_NUM, `DEVMAP_REG_SEL, {up, 1'h1, 10'h000});
    base_sh = {up, 1'h1};
    route({up, BLK, 6'h3f}, 1'h1);
    route({up, BLK + 9'h001, 6'h00}, 1'h0);
    route({up ^ 21'h00_0001, 9'h000, 6'h00}, 1'h0);
    for (int i = 0; i < 16; i++) begin
      blk = 9'($urandom_range(0, 5));
      route({up, blk, 6'($urandom)}, blk <= BLK);
    end
    access(1'h0, 1'h1, `DEVMAP_REG_NUM, `DEVMAP_REG_SEL, {up, 1'h0, 10'h000});
    route({up, 9'h000, 6'h00}, 1'h0);
    $display("test routing done");
    final_report();
  end

endmodule
`default_nettype wire
